// ---- common/dcrs_map.svh ----
`ifndef DCRS_MAP_SVH
`define DCRS_MAP_SVH

// Register offsets on the plain register port
`define DCRS_OFF_REQ_SEL 4'h0
`define DCRS_OFF_CTRL 4'h1
`define DCRS_OFF_STATUS 4'h2

// Field positions and reset values
`define DCRS_FORCE_BIT 15
`define DCRS_NUM_MSB 7
`define DCRS_CTRL_EN_BIT 0
`define DCRS_REQ_RESET 16'h0000
`define DCRS_NUM_RESET 8'h00
`define DCRS_ZERO16 16'h0000
`define DCRS_ZERO7 7'h00

// Status register bit positions
`define DCRS_ST_BUSY 0
`define DCRS_ST_PEND 1
`define DCRS_ST_FORCED 2
`define DCRS_ST_SEL_VALID 3

// Request source numbers
`define DCRS_REQ_EXT_EXTERNAL_INTERRUPT_ZERO 8'h00
`define DCRS_REQ_CAPTURE1 8'h01
`define DCRS_REQ_COMPARE1 8'h02
`define DCRS_REQ_CAPTURE2 8'h05
`define DCRS_REQ_COMPARE2 8'h06
`define DCRS_REQ_TIMER2 8'h07
`define DCRS_REQ_TIMER3 8'h08
`define DCRS_REQ_SYNC1_DONE 8'h0A
`define DCRS_REQ_SERIAL1_RX 8'h0B
`define DCRS_REQ_SERIAL1_TX 8'h0C
`define DCRS_REQ_CONV1_DONE 8'h0D
`define DCRS_REQ_COMPARE3 8'h19
`define DCRS_REQ_COMPARE4 8'h1A
`define DCRS_REQ_TIMER4 8'h1B
`define DCRS_REQ_TIMER5 8'h1C
`define DCRS_REQ_SERIAL2_RX 8'h1E
`define DCRS_REQ_SERIAL2_TX 8'h1F
`define DCRS_REQ_SYNC2_DONE 8'h21
`define DCRS_REQ_CAN_RX 8'h22
`define DCRS_REQ_CAPTURE3 8'h25
`define DCRS_REQ_CAPTURE4 8'h26
`define DCRS_REQ_CAN_TX 8'h46

// Event input vector: width and index of the two CAN sources
`define DCRS_NUM_SRC 22
`define DCRS_IDX_CAN_RX 18
`define DCRS_IDX_CAN_TX 21

`endif

// ---- common/dcrs_pkg.sv ----
`default_nettype none

package dcrs_pkg;

    typedef enum logic [0:0] {
        DCRS_IDLE = 1'b0,
        DCRS_BUSY = 1'b1
    } dcrs_state_t;

    typedef logic [7:0] dcrs_req_num_t;

endpackage

`default_nettype wire

// ---- src/dcrs_channel.sv ----
// Operation
// - Writing force bit one forces one transfer
// - Force clear: only selected peripheral starts transfers
// - Writing zero to force bit does nothing
// - Hardware clears force on completion or disable
// - Low byte holds read-write request number
// - Numbers 01, 05 select capture one, two
// - Numbers 25, 26 select capture three, four
// - Numbers 02, 06 select compare one, two
// - Numbers 19, 1A select compare three, four
// - Numbers 07, 08 select timers two, three
// - Numbers 1B, 1C select timers four, five
// - Numbers 0B, 0C select serial one rx, tx
// - Numbers 1E, 1F select serial two rx, tx
// - Numbers 0A, 21 select synchronous port done
// - 0D selects converter done, 00 interrupt zero
// - 22, 46 select CAN events if present
//
// The register offsets and the address-and-strobe port were left to the implementer.
`include "dcrs_map.svh"

`default_nettype none

module dcrs_channel #(
    parameter bit HAS_CAN = 1'b1,
    parameter int NUM_SRC = `DCRS_NUM_SRC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Peripheral request events, one-cycle pulses
    input wire logic [NUM_SRC-1:0] periph_evt,
    // Transfer engine handshake
    output logic xfer_start,
    output logic xfer_forced,
    output logic xfer_busy,
    input wire logic xfer_done
);

    // Request number for each entry of the event vector
    localparam logic [7:0] SRC_CODE [0:`DCRS_NUM_SRC-1] = '{
        `DCRS_REQ_EXT_EXTERNAL_INTERRUPT_ZERO,
        `DCRS_REQ_CAPTURE1,
        `DCRS_REQ_COMPARE1,
        `DCRS_REQ_CAPTURE2,
        `DCRS_REQ_COMPARE2,
        `DCRS_REQ_TIMER2,
        `DCRS_REQ_TIMER3,
        `DCRS_REQ_SYNC1_DONE,
        `DCRS_REQ_SERIAL1_RX,
        `DCRS_REQ_SERIAL1_TX,
        `DCRS_REQ_CONV1_DONE,
        `DCRS_REQ_COMPARE3,
        `DCRS_REQ_COMPARE4,
        `DCRS_REQ_TIMER4,
        `DCRS_REQ_TIMER5,
        `DCRS_REQ_SERIAL2_RX,
        `DCRS_REQ_SERIAL2_TX,
        `DCRS_REQ_SYNC2_DONE,
        `DCRS_REQ_CAN_RX,
        `DCRS_REQ_CAPTURE3,
        `DCRS_REQ_CAPTURE4,
        `DCRS_REQ_CAN_TX
    };

    dcrs_pkg::dcrs_state_t state_reg;
    dcrs_pkg::dcrs_req_num_t req_num_reg;
    logic force_reg;
    logic chan_en_reg;
    logic auto_pend_reg;
    logic forced_xfer_reg;
    logic xfer_start_reg;
    logic busy_reg;
    logic [15:0] rdata_reg;

    logic [NUM_SRC-1:0] src_hit;
    logic [NUM_SRC-1:0] src_avail;
    logic sel_valid;
    logic sel_evt;
    logic wr_req;
    logic wr_ctrl;
    logic force_set;
    logic force_done;
    logic start_now;

    assign wr_req = reg_wr && (reg_addr == `DCRS_OFF_REQ_SEL);
    assign wr_ctrl = reg_wr && (reg_addr == `DCRS_OFF_CTRL);

    // Request number decode, one comparator per source
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi = gi + 1) begin : g_src
            if (gi == `DCRS_IDX_CAN_RX || gi == `DCRS_IDX_CAN_TX) begin : g_can
                assign src_avail[gi] = HAS_CAN;
            end else begin : g_std
                assign src_avail[gi] = 1'b1;
            end
            assign src_hit[gi] = src_avail[gi] && (req_num_reg == SRC_CODE[gi]);
        end
    endgenerate

    // No hit means no automatic source at all
    assign sel_valid = |src_hit;
    assign sel_evt = |(src_hit & periph_evt);

    // Only a written one sets the force bit; a written zero is ignored
    assign force_set = wr_req && reg_wdata[`DCRS_FORCE_BIT];
    assign force_done = (state_reg == dcrs_pkg::DCRS_BUSY) && xfer_done && forced_xfer_reg;

    assign start_now = (state_reg == dcrs_pkg::DCRS_IDLE) && chan_en_reg &&
                       (force_reg || auto_pend_reg);

    // Request number field
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            req_num_reg <= `DCRS_NUM_RESET;
        end else if (wr_req) begin
            req_num_reg <= reg_wdata[`DCRS_NUM_MSB:0];
        end
    end

    // Channel enable
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            chan_en_reg <= 1'b0;
        end else if (wr_ctrl) begin
            chan_en_reg <= reg_wdata[`DCRS_CTRL_EN_BIT];
        end
    end

    // Force bit: a new set wins over completion, disable clears at once
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            force_reg <= 1'b0;
        end else if (!chan_en_reg) begin
            force_reg <= 1'b0;
        end else if (force_set) begin
            force_reg <= 1'b1;
        end else if (force_done) begin
            force_reg <= 1'b0;
        end
    end

    // Latched automatic request, ignored while manual mode is active
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            auto_pend_reg <= 1'b0;
        end else if (!chan_en_reg || force_reg) begin
            auto_pend_reg <= 1'b0;
        end else if (sel_evt) begin
            auto_pend_reg <= 1'b1;
        end else if (start_now) begin
            auto_pend_reg <= 1'b0;
        end
    end

    // Transfer sequencing: one start pulse, then wait for done
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= dcrs_pkg::DCRS_IDLE;
            forced_xfer_reg <= 1'b0;
            xfer_start_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            xfer_start_reg <= 1'b0;
            unique case (state_reg)
                dcrs_pkg::DCRS_IDLE: begin
                    if (start_now) begin
                        state_reg <= dcrs_pkg::DCRS_BUSY;
                        forced_xfer_reg <= force_reg;
                        xfer_start_reg <= 1'b1;
                        busy_reg <= 1'b1;
                    end
                end
                dcrs_pkg::DCRS_BUSY: begin
                    if (!chan_en_reg || xfer_done) begin
                        state_reg <= dcrs_pkg::DCRS_IDLE;
                        forced_xfer_reg <= 1'b0;
                        busy_reg <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Registered read data, zero for unmapped offsets
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_reg <= `DCRS_ZERO16;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `DCRS_OFF_REQ_SEL: begin
                    rdata_reg <= {force_reg, `DCRS_ZERO7, req_num_reg};
                end
                `DCRS_OFF_CTRL: begin
                    rdata_reg <= `DCRS_ZERO16;
                    rdata_reg[`DCRS_CTRL_EN_BIT] <= chan_en_reg;
                end
                `DCRS_OFF_STATUS: begin
                    rdata_reg <= `DCRS_ZERO16;
                    rdata_reg[`DCRS_ST_BUSY] <= (state_reg == dcrs_pkg::DCRS_BUSY);
                    rdata_reg[`DCRS_ST_PEND] <= auto_pend_reg;
                    rdata_reg[`DCRS_ST_FORCED] <= forced_xfer_reg;
                    rdata_reg[`DCRS_ST_SEL_VALID] <= sel_valid;
                end
                default: begin
                    rdata_reg <= `DCRS_ZERO16;
                end
            endcase
        end else begin
            rdata_reg <= `DCRS_ZERO16;
        end
    end

    assign reg_rdata = rdata_reg;
    assign xfer_start = xfer_start_reg;
    assign xfer_forced = forced_xfer_reg;
    assign xfer_busy = busy_reg;

endmodule

`default_nettype wire

// ---- testbench/dcrs_channel_sva.sv ----
`default_nettype none
module dcrs_channel_sva #(
    parameter bit HAS_CAN = 1'h1,
    parameter int NUM_SRC = 22
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Transfer side
    input wire logic [NUM_SRC-1:0] periph_evt,
    input wire logic xfer_start,
    input wire logic xfer_forced,
    input wire logic xfer_busy,
    input wire logic xfer_done
);
    logic en_q;
    logic [7:0] num_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Shadow of the enable bit and the request number
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            en_q <= 1'h0;
            num_q <= 8'h00;
        end else if (reg_wr && reg_addr == 4'h1) begin
            en_q <= reg_wdata[0];
        end else if (reg_wr && reg_addr == 4'h0) begin
            num_q <= reg_wdata[7:0];
        end
    end
    a_start_one_cycle: assert property (xfer_start |=> !xfer_start)
        else $error("start pulse too long");
    a_start_busy: assert property (xfer_start |-> xfer_busy)
        else $error("start without busy");
    a_forced_busy: assert property (xfer_forced |-> xfer_busy)
        else $error("forced while idle");
    a_force_starts: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[15] && en_q
        ##1 !xfer_busy && !(reg_wr && reg_addr == 4'h1) |=> xfer_start && xfer_forced)
        else $error("force write gave no forced start");
    a_off_no_start: assert property (!$past(en_q) |-> !xfer_start)
        else $error("start while disabled");
    a_done_ends_busy: assert property (xfer_busy && xfer_done |=> !xfer_busy)
        else $error("busy after done");
    a_disable_aborts: assert property (reg_wr && reg_addr == 4'h1 && !reg_wdata[0]
        |=> ##1 !xfer_busy && !xfer_forced)
        else $error("busy after disable");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside read slot");
    a_num_readback: assert property (reg_rd && reg_addr == 4'h0
        |=> reg_rdata[14:0] == {7'h00, num_q})
        else $error("request number readback wrong");
    c_forced: cover property (xfer_start && xfer_forced);
    c_auto: cover property (xfer_start && !xfer_forced);
    c_done: cover property (xfer_busy && xfer_done);
endmodule
bind dcrs_channel dcrs_channel_sva #(.HAS_CAN(HAS_CAN), .NUM_SRC(NUM_SRC)) u_sva (.sys_clk,
    .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .periph_evt, .xfer_start,
    .xfer_forced, .xfer_busy, .xfer_done);
`default_nettype wire

// ---- testbench/dcrs_periph_model.sv ----
`default_nettype none
module dcrs_periph_model (
    // Clock, reset and bench control
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [21:0] evt_req,
    input wire logic [4:0] lat,
    // Channel side
    input wire logic xfer_start,
    input wire logic xfer_busy,
    output logic [21:0] periph_evt,
    output logic xfer_done
);
    logic [4:0] cnt;
    always_ff @(posedge sys_clk) begin
        periph_evt <= evt_req;
        if (rst) cnt <= 5'h00;
        else if (xfer_start) cnt <= lat;
        else if (cnt != 5'h00) cnt <= cnt - 5'h01;
        // Completion only while the channel is still busy
        xfer_done <= !rst && xfer_busy && cnt == 5'h01;
    end
endmodule
`default_nettype wire

// ---- testbench/dcrs_channel_test.sv ----
`default_nettype none
module dcrs_channel_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst, reg_wr, reg_rd, xfer_start, xfer_forced, xfer_busy, xfer_done;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, v;
    logic [21:0] periph_evt, evt_req;
    logic [4:0] lat;
    logic [7:0] nums [22] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0A,
        8'h0B, 8'h0C, 8'h0D, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1E, 8'h1F, 8'h21, 8'h22,
        8'h25, 8'h26, 8'h46};
    int failures = 0;
    int comparisons = 0;
    dcrs_channel DUT (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .periph_evt, .xfer_start, .xfer_forced, .xfer_busy, .xfer_done);
    dcrs_periph_model partner (.sys_clk, .rst, .evt_req, .lat, .xfer_start, .xfer_busy,
        .periph_evt, .xfer_done);
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        #1 d = reg_rdata;
    endtask
    // Raise events, then report {start, forced} of any start in six cycles
    task automatic watch(input logic [21:0] m, output logic [15:0] s);
        evt_req <= m;
        s = 16'h0000;
        repeat (6) begin
            @(posedge sys_clk);
            evt_req <= 22'h000000;
            #1 if (xfer_start === 1'h1) s = {14'h0000, 1'h1, xfer_forced};
        end
    endtask
    task automatic idle;
        for (int k = 0; k < 40 && xfer_busy !== 1'h0; k++) @(posedge sys_clk);
    endtask
    task automatic t_regs;
        rd(4'h0, v);
        chk("request reset", v, 16'h0000);
        rd(4'h7, v);
        chk("unmapped read", v, 16'h0000);
        wr(4'h0, 16'h7FA5);
        rd(4'h0, v);
        chk("request readback", v, 16'h00A5);
    endtask
    task automatic t_select;
        rd(4'h1, v);
        chk("enable readback", v, 16'h0001);
        for (int i = 0; i < 22; i++) begin
            wr(4'h0, {8'h00, nums[i]});
            watch(22'h000001 << ((i + 1) % 22), v);
            chk("other source", v, 16'h0000);
            watch(22'h000001 << i, v);
            chk("own source", v, 16'h0002);
            idle;
        end
        wr(4'h0, 16'h0003);
        watch(22'h3FFFFF, v);
        chk("unassigned", v, 16'h0000);
    endtask
    task automatic t_force;
        lat <= 5'h14;
        wr(4'h0, 16'h8005);
        watch(22'h000000, v);
        chk("forced start", v, 16'h0003);
        wr(4'h0, 16'h0005);
        rd(4'h0, v);
        chk("force kept", v, 16'h8005);
        rd(4'h2, v);
        chk("forced status", v, 16'h000D);
        idle;
        rd(4'h0, v);
        chk("force done", v, 16'h0005);
        watch(22'h000000, v);
        chk("single transfer", v, 16'h0000);
        wr(4'h0, 16'h8005);
        watch(22'h000000, v);
        wr(4'h1, 16'h0000);
        rd(4'h0, v);
        chk("disable clears", v, 16'h0005);
        chk("disable aborts", {15'h0000, xfer_busy}, 16'h0000);
    endtask
    task automatic tally_and_finish;
        if (failures == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        tally_and_finish;
    end
    initial begin
        rst = 1'h1;
        {reg_wr, reg_rd, reg_addr, reg_wdata, evt_req} = '0;
        lat = 5'h02;
        repeat (4) @(posedge sys_clk);
        rst <= 1'h0;
        t_regs;
        wr(4'h1, 16'h0001);
        t_select;
        t_force;
        tally_and_finish;
    end
endmodule
`default_nettype wire
